// file: uge_regs.vh
// uge_regs.vh: register offsets, field positions, codes and reset values of the gate evaluator.
// assumes inclusion by bare name from the design files; definitions only.
`ifndef UGE_REGS_VH
`define UGE_REGS_VH

`define UGE_OFS_CTRL 8'h00
`define UGE_OFS_IFPOS 8'h04
`define UGE_OFS_APOS 8'h08
`define UGE_OFS_BPOS 8'h0c
`define UGE_OFS_THR 8'h10
`define UGE_OFS_DISP 8'h14
`define UGE_OFS_STAT 8'h18
`define UGE_OFS_ARES 8'h1c
`define UGE_OFS_BRES 8'h20

`define UGE_CTRL_IFLOG 1:0
`define UGE_CTRL_ALOG 3:2
`define UGE_CTRL_BLOG 5:4
`define UGE_CTRL_ATOF 6
`define UGE_CTRL_BTOF 7
`define UGE_CTRL_SHAPE 8
`define UGE_CTRL_ALSEL 10:9
`define UGE_CTRL_DSTART 12:11
`define UGE_CTRL_ASHOW 13
`define UGE_CTRL_BSHOW 14
`define UGE_CTRL_SECTOR 15
`define UGE_CTRL_RST 32'h0000_6000

`define UGE_LOG_OFF 2'h0
`define UGE_LOG_POS 2'h1
`define UGE_LOG_NEG 2'h2

`define UGE_TOF_FLANK 1'h0
`define UGE_TOF_PEAK 1'h1

`define UGE_SHAPE_DEPTH 1'h0
`define UGE_SHAPE_IMAGE 1'h1

`define UGE_AL_A 2'h0
`define UGE_AL_B 2'h1
`define UGE_AL_AORB 2'h2
`define UGE_AL_OFF 2'h3

`define UGE_DS_IP 2'h0
`define UGE_DS_IF 2'h1
`define UGE_DS_MAT 2'h2

`define UGE_POS_RST 32'h0000_0000
`define UGE_THR_RST 32'h0000_0000
`define UGE_DISP_RST 32'hffff_0000

`endif

// file: uge_gate.v
// uge_gate.v: one gate, evaluated over one beam acquisition.
// assumes pos is in the gate's own coordinate and posOk already holds range and reference checks.
`timescale 1ns/10ps
module uge_gate (
	input wire clk,
	input wire reset,
	input wire beamStart,
	input wire beamEnd,
	input wire sampleValid,
	input wire [9:0] amp,
	input wire [15:0] pos,
	input wire posOk,
	input wire [15:0] start,
	input wire [15:0] width,
	input wire [9:0] threshold,
	input wire [1:0] logicSel,
	input wire tofMode,
	output reg crossed_ff,
	output reg [15:0] hitPos_ff,
	output reg trig_ff,
	output reg [15:0] tof_ff,
	output reg [9:0] peakAmp_ff
);
`include "uge_regs.vh"

	reg [15:0] peakPos_ff;
	reg [9:0] curPeak_ff;
	wire [16:0] gateEnd;
	wire inGate;
	wire over;

	assign gateEnd = {1'b0, start} + {1'b0, width};
	assign inGate = posOk && ({1'b0, pos} >= {1'b0, start}) && ({1'b0, pos} < gateEnd);
	assign over = sampleValid && inGate && (amp >= threshold);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			crossed_ff <= 1'b0;
			hitPos_ff <= 16'h0000;
			peakPos_ff <= 16'h0000;
			curPeak_ff <= 10'h000;
			trig_ff <= 1'b0;
			tof_ff <= 16'h0000;
			peakAmp_ff <= 10'h000;
		end else if (beamStart) begin
			// fresh evaluation per acquisition
			crossed_ff <= 1'b0;
			curPeak_ff <= 10'h000;
		end else if (beamEnd) begin
			case (logicSel)
				`UGE_LOG_POS: trig_ff <= crossed_ff;
				`UGE_LOG_NEG: trig_ff <= ~crossed_ff;
				default: trig_ff <= 1'b0;
			endcase
			tof_ff <= (tofMode == `UGE_TOF_PEAK) ? peakPos_ff : hitPos_ff;
			peakAmp_ff <= curPeak_ff;
		end else if (over) begin
			if (!crossed_ff) begin
				crossed_ff <= 1'b1;
				hitPos_ff <= pos;
			end
			if (!crossed_ff || amp > curPeak_ff) begin
				curPeak_ff <= amp;
				peakPos_ff <= pos;
			end
		end
	end
endmodule

// file: uge_main.v
// uge_main.v: gate evaluator top with APB register slave, IF/A/B gates and alarm drive.
// assumes one clock, samples arrive between beamStart and beamEnd pulses, and a zero-wait APB master.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - A/B start relative to IF trigger point
// - IF gate gives position only, no data
// - hidden A/B gates keep evaluating normally
// - IF logic off disables and hides it
// - IF loss flagged only in IF display start
// - crossing needs amplitude at or above threshold
// - time-of-flight at flank or peak
// - positive logic triggers on a crossing
// - negative logic only for A and B
// - logic off never triggers
// - sector scan only with IF logic off
// - sector scan gates use material depth
// - depth mode counts off-screen triggers
// - reset selects depth-based range mode
// - image mode clips A and B gates to display range
// - switching to image mode snaps A and B gates
// - width change keeps start unchanged
// - alarm source A, B, either or none
// - source none never activates alarm
// - triggered gate lights alarm unless off
module uge_main (
	input wire clk,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire beamStart,
	input wire beamEnd,
	input wire sampleValid,
	input wire [9:0] sampleAmp,
	input wire [15:0] beamCos,
	output reg alarmOut,
	output reg alarmLight,
	output reg ifLossColor,
	output reg ifGateShown,
	output reg aGateShown,
	output reg bGateShown,
	output reg sectorActive
);
`include "uge_regs.vh"

	reg [31:0] ctrl_ff;
	reg [31:0] ifPos_ff;
	reg [31:0] aPos_ff;
	reg [31:0] bPos_ff;
	reg [31:0] thr_ff;
	reg [31:0] disp_ff;
	reg [31:0] prdata_ff;
	reg slvErr_ff;
	reg snapPend_ff;
	reg [15:0] posCnt_ff;
	reg beamEndD_ff;
	reg ifLoss_ff;
	reg alarm_ff;
	reg [31:0] nxt_ctrl;
	reg [31:0] nxt_rd;
	reg nxt_err;
	reg nxt_alarm;

	wire wrEn;
	wire setup;
	wire [1:0] ifLogic;
	wire [1:0] aLogic;
	wire [1:0] bLogic;
	wire imageMode;
	wire ifRefOn;
	wire sectorOn;
	wire [31:0] prod;
	wire [15:0] rawPos;
	wire [15:0] relPos;
	wire dispOk;
	wire abOk;
	wire ifCrossed;
	wire [15:0] ifHit;
	wire ifTrig;
	wire aTrig;
	wire bTrig;
	wire [15:0] aTof;
	wire [15:0] bTof;
	wire [9:0] aAmp;
	wire [9:0] bAmp;

	// pull a gate inside [dispStart, dispEnd], start first, then trim width
	function [31:0] snapGate;
		input [31:0] gp;
		input [31:0] dp;
		reg [16:0] s;
		reg [16:0] e;
		begin
			s = {1'b0, gp[15:0]};
			e = {1'b0, gp[15:0]} + {1'b0, gp[31:16]};
			if (s < {1'b0, dp[15:0]})
				s = {1'b0, dp[15:0]};
			if (e > {1'b0, dp[31:16]})
				e = {1'b0, dp[31:16]};
			if (e < s)
				e = s;
			snapGate = {e[15:0] - s[15:0], s[15:0]};
		end
	endfunction

	// apb: read data captured in setup so the access phase completes at once
	assign setup = psel && !penable;
	assign wrEn = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && slvErr_ff;

	assign ifLogic = ctrl_ff[`UGE_CTRL_IFLOG];
	assign aLogic = ctrl_ff[`UGE_CTRL_ALOG];
	assign bLogic = ctrl_ff[`UGE_CTRL_BLOG];
	assign imageMode = ctrl_ff[`UGE_CTRL_SHAPE] == `UGE_SHAPE_IMAGE;
	assign ifRefOn = ifLogic == `UGE_LOG_POS;
	// a sector request waits until the IF gate is switched off
	assign sectorOn = ctrl_ff[`UGE_CTRL_SECTOR] && (ifLogic == `UGE_LOG_OFF);

	// material depth = sound path times cos(angle); beamCos is unsigned Q1.15
	assign prod = posCnt_ff * beamCos;
	assign rawPos = sectorOn ? prod[30:15] : posCnt_ff;
	assign relPos = ifRefOn ? rawPos - ifHit : rawPos;
	// depth mode keeps off-screen hits; image mode clips to the display span
	assign dispOk = !imageMode || ((rawPos >= disp_ff[15:0]) && (rawPos <= disp_ff[31:16]));
	// a/b wait for the reference echo before they can open
	assign abOk = dispOk && (!ifRefOn || ifCrossed);

	always @* begin
		nxt_ctrl = pwdata;
		// negative logic is refused for the IF gate; old setting kept
		if (pwdata[`UGE_CTRL_IFLOG] == `UGE_LOG_NEG)
			nxt_ctrl[`UGE_CTRL_IFLOG] = ifLogic;
		nxt_ctrl[31:16] = 16'h0000;
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_ff <= `UGE_CTRL_RST;
			ifPos_ff <= `UGE_POS_RST;
			aPos_ff <= `UGE_POS_RST;
			bPos_ff <= `UGE_POS_RST;
			thr_ff <= `UGE_THR_RST;
			disp_ff <= `UGE_DISP_RST;
			snapPend_ff <= 1'b0;
		end else begin
			snapPend_ff <= 1'b0;
			// snap works on stored coordinates; an IF-relative gate is not shifted by the hit
			if (snapPend_ff) begin
				aPos_ff <= snapGate(aPos_ff, disp_ff);
				bPos_ff <= snapGate(bPos_ff, disp_ff);
			end
			if (wrEn) begin
				if (paddr == `UGE_OFS_CTRL) begin
					ctrl_ff <= nxt_ctrl;
					snapPend_ff <= !imageMode && (nxt_ctrl[`UGE_CTRL_SHAPE] == `UGE_SHAPE_IMAGE);
				end else if (paddr == `UGE_OFS_IFPOS) begin
					ifPos_ff <= pwdata;
				end else if (paddr == `UGE_OFS_APOS) begin
					aPos_ff <= pwdata;
				end else if (paddr == `UGE_OFS_BPOS) begin
					bPos_ff <= pwdata;
				end else if (paddr == `UGE_OFS_THR) begin
					thr_ff <= {2'h0, pwdata[29:0]};
				end else if (paddr == `UGE_OFS_DISP) begin
					disp_ff <= pwdata;
				end
			end
		end
	end

	always @* begin
		nxt_rd = 32'h0000_0000;
		nxt_err = 1'b0;
		if (paddr == `UGE_OFS_CTRL) begin
			nxt_rd = ctrl_ff;
		end else if (paddr == `UGE_OFS_IFPOS) begin
			nxt_rd = ifPos_ff;
		end else if (paddr == `UGE_OFS_APOS) begin
			nxt_rd = aPos_ff;
		end else if (paddr == `UGE_OFS_BPOS) begin
			nxt_rd = bPos_ff;
		end else if (paddr == `UGE_OFS_THR) begin
			nxt_rd = thr_ff;
		end else if (paddr == `UGE_OFS_DISP) begin
			nxt_rd = disp_ff;
		end else if (paddr == `UGE_OFS_STAT) begin
			// bit 2 stays zero: the interface gate positions the others and reports nothing
			nxt_rd = {26'h0, alarm_ff, sectorOn, ifLoss_ff, 1'b0, bTrig, aTrig};
		end else if (paddr == `UGE_OFS_ARES) begin
			nxt_rd = {6'h0, aAmp, aTof};
		end else if (paddr == `UGE_OFS_BRES) begin
			nxt_rd = {6'h0, bAmp, bTof};
		end else begin
			nxt_err = 1'b1;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_ff <= 32'h0000_0000;
			slvErr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff <= nxt_rd;
			slvErr_ff <= nxt_err;
		end
	end

	always @* begin
		prdata = prdata_ff;
	end

	// sample index within the current beam
	// samples outside a beam still advance the index, so drive beamStart first
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			posCnt_ff <= 16'h0000;
			beamEndD_ff <= 1'b0;
		end else begin
			beamEndD_ff <= beamEnd;
			if (beamStart)
				posCnt_ff <= 16'h0000;
			else if (sampleValid)
				posCnt_ff <= posCnt_ff + 16'h0001;
		end
	end

	// IF gate: its hit position, crossing and trigger feed A/B and the loss flag; its own trigger is not reported
	uge_gate ifGate (
		.clk(clk),
		.reset(reset),
		.beamStart(beamStart),
		.beamEnd(beamEnd),
		.sampleValid(sampleValid),
		.amp(sampleAmp),
		.pos(rawPos),
		.posOk(1'b1),
		.start(ifPos_ff[15:0]),
		.width(ifPos_ff[31:16]),
		.threshold(thr_ff[9:0]),
		.logicSel(ifLogic),
		.tofMode(`UGE_TOF_FLANK),
		.crossed_ff(ifCrossed),
		.hitPos_ff(ifHit),
		.trig_ff(ifTrig),
		.tof_ff(),
		.peakAmp_ff()
	);

	// display flags never gate evaluation of A and B
	uge_gate aGate (
		.clk(clk),
		.reset(reset),
		.beamStart(beamStart),
		.beamEnd(beamEnd),
		.sampleValid(sampleValid),
		.amp(sampleAmp),
		.pos(relPos),
		.posOk(abOk),
		.start(aPos_ff[15:0]),
		.width(aPos_ff[31:16]),
		.threshold(thr_ff[19:10]),
		.logicSel(aLogic),
		.tofMode(ctrl_ff[`UGE_CTRL_ATOF]),
		.crossed_ff(),
		.hitPos_ff(),
		.trig_ff(aTrig),
		.tof_ff(aTof),
		.peakAmp_ff(aAmp)
	);

	uge_gate bGate (
		.clk(clk),
		.reset(reset),
		.beamStart(beamStart),
		.beamEnd(beamEnd),
		.sampleValid(sampleValid),
		.amp(sampleAmp),
		.pos(relPos),
		.posOk(abOk),
		.start(bPos_ff[15:0]),
		.width(bPos_ff[31:16]),
		.threshold(thr_ff[29:20]),
		.logicSel(bLogic),
		.tofMode(ctrl_ff[`UGE_CTRL_BTOF]),
		.crossed_ff(),
		.hitPos_ff(),
		.trig_ff(bTrig),
		.tof_ff(bTof),
		.peakAmp_ff(bAmp)
	);

	// gate trig goes low at the first beam end with its logic off
	always @* begin
		case (ctrl_ff[`UGE_CTRL_ALSEL])
			`UGE_AL_A: nxt_alarm = aTrig;
			`UGE_AL_B: nxt_alarm = bTrig;
			`UGE_AL_AORB: nxt_alarm = aTrig | bTrig;
			default: nxt_alarm = 1'b0;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			alarm_ff <= 1'b0;
			ifLoss_ff <= 1'b0;
		end else begin
			alarm_ff <= nxt_alarm;
			// loss only meaningful when the display is anchored on the interface echo
			if (beamEndD_ff)
				ifLoss_ff <= (ctrl_ff[`UGE_CTRL_DSTART] == `UGE_DS_IF) && ifRefOn && !ifTrig;
			else if (ctrl_ff[`UGE_CTRL_DSTART] != `UGE_DS_IF)
				ifLoss_ff <= 1'b0;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			alarmOut <= 1'b0;
			alarmLight <= 1'b0;
			ifLossColor <= 1'b0;
			ifGateShown <= 1'b0;
			aGateShown <= 1'b0;
			bGateShown <= 1'b0;
			sectorActive <= 1'b0;
		end else begin
			alarmOut <= nxt_alarm;
			alarmLight <= nxt_alarm;
			ifLossColor <= ifLoss_ff;
			ifGateShown <= ifLogic != `UGE_LOG_OFF;
			aGateShown <= ctrl_ff[`UGE_CTRL_ASHOW] && (aLogic != `UGE_LOG_OFF);
			bGateShown <= ctrl_ff[`UGE_CTRL_BSHOW] && (bLogic != `UGE_LOG_OFF);
			sectorActive <= sectorOn;
		end
	end
endmodule

// file: uge_main_checker.sv
// uge_main_checker.sv: port-level assertions for the gate evaluator.
// assumes bind onto uge_main; ctrl is shadowed from apb writes seen at the ports.
`timescale 1ns/10ps
module uge_main_checker (
	input wire clk,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire beamEnd,
	input wire alarmOut,
	input wire alarmLight,
	input wire ifLossColor,
	input wire ifGateShown,
	input wire sectorActive
);
	reg [15:0] ctl_ff;
	reg [2:0] age_ff;
	// if logic code 2 is refused by the design, so the shadow keeps the old field too
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_ff <= 16'h6000;
			age_ff <= 3'h0;
		end else if (psel && penable && pwrite && paddr == 8'h00) begin
			ctl_ff <= {pwdata[15:2], (pwdata[1:0] == 2'h2) ? ctl_ff[1:0] : pwdata[1:0]};
			age_ff <= 3'h0;
		end else if (age_ff != 3'h7) begin
			age_ff <= age_ff + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_alarm_pair_equal: assert property (alarmOut == alarmLight) else $error("alarm output and light differ");
	a_none_stays_dark: assert property (age_ff >= 3'h2 && ctl_ff[10:9] == 2'h3 |-> !alarmOut) else $error("alarm with source none");
	a_if_shown_logic: assert property (age_ff >= 3'h2 |-> ifGateShown == (ctl_ff[1:0] != 2'h0)) else $error("if gate display wrong");
	a_sector_needs_ifoff: assert property (age_ff >= 3'h2 |-> sectorActive == (ctl_ff[15] && ctl_ff[1:0] == 2'h0)) else $error("sector flag wrong");
	a_loss_only_ifstart: assert property (age_ff >= 3'h2 && ctl_ff[12:11] != 2'h1 |-> !ifLossColor) else $error("loss colour outside if start");
	a_alarm_change_cause: assert property (!$stable(alarmOut) |-> $past(beamEnd, 2) || $past(beamEnd, 3) || age_ff <= 3'h4) else $error("alarm moved without a beam end");
	a_pready_always: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h20 |-> pslverr) else $error("no error on unmapped address");
	a_mapped_no_err: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped address");
endmodule
bind uge_main uge_main_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .beamEnd(beamEnd), .alarmOut(alarmOut),
	.alarmLight(alarmLight), .ifLossColor(ifLossColor), .ifGateShown(ifGateShown), .sectorActive(sectorActive));

// file: uge_panel.sv
// uge_panel.sv: front panel model, an alarm lamp and a logic-level output socket.
// assumes both are driven from one source; it counts cycles where they disagree.
`timescale 1ns/10ps
module uge_panel (
	input wire clk,
	input wire reset,
	input wire alarmOut,
	input wire alarmLight,
	output reg [7:0] splitCount
);
	// lamp and socket must follow the same selected source
	always @(posedge clk or posedge reset) begin
		if (reset) splitCount <= 8'h00;
		else if (alarmOut !== alarmLight && splitCount != 8'hff) splitCount <= splitCount + 8'h01;
	end
endmodule

// file: tb_top.sv
// tb_top.sv: random beams against an integer gate model, then directed register cases.
// assumes zero-wait apb and ifGate logic off during the random beams.
`timescale 1ns/10ps
module tb_top;
	reg clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, beamStart = 0, beamEnd = 0, sampleValid = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rs = 39, rd, cw;
	reg [9:0] sampleAmp = 10'h000;
	reg [15:0] beamCos = 16'h8000;
	reg er;
	wire pready, pslverr, alarmOut, alarmLight, ifLossColor, ifGateShown, aGateShown, bGateShown, sectorActive;
	wire [31:0] prdata;
	wire [7:0] splitCount;
	integer miscompares = 0, cmp_count = 0, i, k, g, ea, al;
	integer amp[0:23], st[0:1], wd[0:1], th[0:1], lg[0:1], tm[0:1], trg[0:1], tof[0:1], cr[0:1], pk[0:1];
	always #5 clk = ~clk;
	uge_main uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .beamStart(beamStart),
		.beamEnd(beamEnd), .sampleValid(sampleValid), .sampleAmp(sampleAmp), .beamCos(beamCos),
		.alarmOut(alarmOut), .alarmLight(alarmLight), .ifLossColor(ifLossColor), .ifGateShown(ifGateShown),
		.aGateShown(aGateShown), .bGateShown(bGateShown), .sectorActive(sectorActive));
	uge_panel panel (.clk(clk), .reset(reset), .alarmOut(alarmOut), .alarmLight(alarmLight), .splitCount(splitCount));
	function [31:0] xs(input [31:0] v);
		reg [31:0] x;
		begin
			x = v ^ (v << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task chk(input string n, input [31:0] e, input [31:0] s);
		cmp_count = cmp_count + 1;
		if (e !== s) begin
			$display("BAD %s expected %h seen %h", n, e, s);
			miscompares = miscompares + 1;
		end
	endtask
	// holds the request until pready is sampled high, then takes data and response
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task beam;
		@(posedge clk) beamStart <= 1;
		for (k = 0; k < 24; k = k + 1) begin
			@(posedge clk);
			beamStart <= 0; sampleValid <= 1; sampleAmp <= amp[k][9:0];
		end
		@(posedge clk) sampleValid <= 0;
		@(posedge clk) beamEnd <= 1;
		@(posedge clk) beamEnd <= 0;
		repeat (4) @(posedge clk);
	endtask
	// one beam whose only echoes stand at samples a and b
	task echo(input integer a, input integer b);
		for (k = 0; k < 24; k = k + 1) amp[k] = (k == a || k == b) ? 40 : 0;
		beam;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		miscompares = miscompares + 1;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge clk);
		reset <= 0;
		apb(0, 8'h00, 0); chk("ctrl reset", 32'h6000, rd);
		apb(0, 8'h14, 0); chk("disp reset", 32'hffff0000, rd);
		apb(0, 8'h40, 0); chk("unmapped err", 1, er); chk("unmapped data", 0, rd);
		for (i = 0; i < 24; i = i + 1) begin
			for (g = 0; g < 2; g = g + 1) begin
				rs = xs(rs);
				st[g] = rs[3:0]; wd[g] = rs[7:4]; th[g] = rs[13:8]; lg[g] = rs[17:16] % 3; tm[g] = rs[18];
			end
			rs = xs(rs);
			al = rs[1:0];
			cw = {16'h0, 1'b0, rs[3], rs[2], 2'h0, rs[1:0], 1'b0, tm[1][0], tm[0][0], lg[1][1:0], lg[0][1:0], 2'h0};
			for (k = 0; k < 24; k = k + 1) begin
				rs = xs(rs);
				amp[k] = rs[5:0];
			end
			apb(1, 8'h08, {wd[0][15:0], st[0][15:0]});
			apb(1, 8'h0c, {wd[1][15:0], st[1][15:0]});
			apb(1, 8'h10, {2'h0, th[1][9:0], th[0][9:0], 10'h000});
			apb(1, 8'h00, cw);
			beam;
			for (g = 0; g < 2; g = g + 1) begin
				cr[g] = 0;
				for (k = 0; k < 24; k = k + 1) begin
					if (k >= st[g] && k < st[g] + wd[g] && amp[k] >= th[g]) begin
						if (cr[g] == 0 || amp[k] > pk[g]) begin
							if (cr[g] == 0 || tm[g] == 1) tof[g] = k;
							cr[g] = 1;
							pk[g] = amp[k];
						end
					end
				end
				trg[g] = (lg[g] == 1) ? cr[g] : (lg[g] == 2) ? !cr[g] : 0;
			end
			ea = (al == 0) ? trg[0] : (al == 1) ? trg[1] : (al == 2) ? (trg[0] | trg[1]) : 0;
			apb(0, 8'h18, 0);
			chk("stat", {26'h0, ea[0], 3'h0, trg[1][0], trg[0][0]}, rd & 32'h23);
			chk("alarm", ea, alarmOut);
			chk("a shown", cw[13] && lg[0] != 0, aGateShown);
			chk("b shown", cw[14] && lg[1] != 0, bGateShown);
			for (g = 0; g < 2; g = g + 1) begin
				if (cr[g] == 1 && lg[g] != 0) begin
					apb(0, g ? 8'h20 : 8'h1c, 0);
					chk("tof", tof[g], rd[15:0]);
					chk("peak amp", pk[g], rd[25:16]);
				end
			end
		end
		apb(1, 8'h10, {2'h0, 10'h01e, 10'h01e, 10'h01e});
		apb(1, 8'h04, {16'h0004, 16'h0002});
		apb(1, 8'h08, {16'h0004, 16'h0003});
		apb(1, 8'h0c, {16'h0002, 16'h0000});
		apb(1, 8'h00, 32'h6815);
		echo(4, 9);
		apb(0, 8'h18, 0);
		chk("stat if ref", 32'h21, rd);
		apb(0, 8'h1c, 0);
		chk("tof if ref", 5, rd[15:0]);
		chk("if shown", 1, ifGateShown);
		chk("loss clear", 0, ifLossColor);
		echo(9, 9);
		apb(0, 8'h18, 0);
		chk("stat if lost", 32'h08, rd);
		chk("loss colour", 1, ifLossColor);
		apb(1, 8'h00, 32'h6015);
		apb(0, 8'h00, 0);
		chk("ctrl ip start", 32'h6015, rd);
		chk("loss other start", 0, ifLossColor);
		beamCos <= 16'h4000;
		apb(1, 8'h08, {16'h0001, 16'h0005});
		apb(1, 8'h00, 32'he004);
		echo(10, 10);
		apb(0, 8'h1c, 0);
		chk("tof depth", 5, rd[15:0]);
		apb(0, 8'h18, 0);
		chk("stat depth", 32'h31, rd);
		chk("alarm depth", 1, alarmOut);
		beamCos <= 16'h8000;
		apb(1, 8'h14, {16'h0014, 16'h000c});
		apb(1, 8'h08, {16'h0008, 16'h0008});
		apb(1, 8'h00, 32'h6004);
		echo(9, 13);
		apb(0, 8'h1c, 0);
		chk("tof off screen", 9, rd[15:0]);
		apb(1, 8'h00, 32'h6104);
		apb(0, 8'h08, 0);
		chk("snap image", {16'h0004, 16'h000c}, rd);
		apb(1, 8'h08, {16'h0008, 16'h0008});
		echo(9, 13);
		apb(0, 8'h1c, 0);
		chk("tof clipped", 13, rd[15:0]);
		apb(1, 8'h00, 32'h6001); apb(1, 8'h00, 32'h6002);
		apb(0, 8'h00, 0); chk("if neg refused", 32'h6001, rd);
		apb(1, 8'h00, 32'he000); apb(0, 8'h18, 0); chk("sector on", 1, rd[4]);
		apb(1, 8'h00, 32'he001); apb(0, 8'h18, 0); chk("sector off", 0, rd[4]);
		apb(1, 8'h08, {16'd100, 16'd0}); apb(1, 8'h14, {16'd50, 16'd10});
		apb(1, 8'h00, 32'h6100); apb(0, 8'h08, 0); chk("snap", {16'd40, 16'd10}, rd);
		chk("panel split", 0, splitCount);
		tally_and_finish;
	end
endmodule
